/* File: oto_pkg.sv */
// Package for the on-screen text overlay: register map, field positions,
// reset values, timing counts, state encodings and the size decode.
// Assumes a 40 MHz system clock and byte addresses on the register bus.
package oto_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the 10-bit bus address.
	localparam logic [9:0] VORG_OFS = 10'h000;
	localparam logic [9:0] HORG_OFS = 10'h004;
	localparam logic [9:0] GAPB_OFS = 10'h008;
	localparam logic [9:0] WGSZ_OFS = 10'h00c;
	localparam logic [9:0] BKD_OFS = 10'h010;
	localparam logic [9:0] BANK_OFS = 10'h014;
	localparam logic [9:0] MEN_OFS = 10'h018;
	localparam logic [9:0] STAT_OFS = 10'h01c;
	localparam logic [9:0] RAM_BASE = 10'h100;
	localparam logic [6:0] RAM_ENTRIES = 7'h50;
	localparam logic [2:0] LAST_DISP_LINE = 3'h4;
	localparam logic [3:0] LAST_COL = 4'hf;

	////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int VAL_MSB = 5;
	localparam int FLAG_BIT = 6;
	localparam int GS_LSB = 6;
	localparam int KIND_BIT = 6;
	localparam int HDR_S_BIT = 6;
	localparam int RGB_LSB = 3;
	localparam int BGS_BIT = 2;
	localparam int WE_BIT = 1;
	localparam int GAPF_BIT = 0;
	localparam int BK_C0_LSB = 0;
	localparam int BK_C1_LSB = 3;
	localparam int BK_ON0_BIT = 6;
	localparam int BK_ON1_BIT = 7;

	////////////////////////////////////////////////////////////////////////
	// Reset values. Vertical origin and gap start at 1 since zero is illegal.
	localparam logic [6:0] VORG_RST = 7'h01;
	localparam logic [6:0] HORG_RST = 7'h00;
	localparam logic [6:0] GAPB_RST = 7'h01;
	localparam logic [7:0] WGSZ_RST = 8'h00;
	localparam logic [7:0] BKD_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing. One pixel tick is two overlay oscillator periods.
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_PERIOD_NS = 400;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
	localparam logic [6:0] LEAD_BASE_TICKS = 7'h0a;
	localparam logic [2:0] GLYPH_LAST_COL = 3'h5;
	localparam logic [3:0] GLYPH_LAST_ROW = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// State encodings.
	typedef enum logic [1:0] {
		V_WAIT = 2'b00,
		V_ROW = 2'b01,
		V_GAP = 2'b10,
		V_DONE = 2'b11
	} oto_vstate_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LEAD = 2'b01,
		H_CHAR = 2'b10,
		H_GAP = 2'b11
	} oto_hstate_t;

	// Size code {global size, line size} to multiple of the smallest cell.
	function automatic logic [2:0] size_scale(input logic [1:0] gs,
		input logic s);
		case ({gs, s})
			3'h1: size_scale = 3'h2;
			3'h3: size_scale = 3'h3;
			3'h4: size_scale = 3'h2;
			3'h5: size_scale = 3'h3;
			3'h6: size_scale = 3'h2;
			3'h7: size_scale = 3'h4;
			default: size_scale = 3'h1;
		endcase
	endfunction

endpackage

/* File: oto_sync.sv */
// Two-flop synchroniser with rising-edge pulse for one sync pin.
// Assumes the pin is asynchronous to sys_clk and pulses are several
// clocks wide.
`timescale 1ns/1ps
module oto_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Pin and pulse
	input wire logic pin_in,
	output logic rise_pulse
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign rise_pulse = sync_reg & ~prev_reg;
endmodule // oto_sync

/* File: oto_char_ram.sv */
// Character memory of 80 seven-bit entries, five lines of sixteen.
// Assumes one write port from the bus and asynchronous read ports.
`timescale 1ns/1ps
module oto_char_ram (
	// Clock
	input wire logic sys_clk,
	// Write port
	input wire logic wr_en,
	input wire logic [6:0] wr_idx,
	input wire logic [6:0] wr_data,
	// Bus read port
	input wire logic [6:0] bus_idx,
	output logic [6:0] bus_data,
	// Display read ports
	input wire logic [6:0] disp_idx,
	output logic [6:0] disp_data,
	input wire logic [2:0] hdr_line,
	output logic [6:0] hdr_data
);
	logic [6:0] mem [0:79];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign bus_data = mem[bus_idx];
	assign disp_data = mem[disp_idx];
	// Column 0 of each line is its header entry.
	assign hdr_data = mem[{hdr_line, 4'h0}];
endmodule // oto_char_ram

/* File: oto_overlay.sv */
// On-screen text overlay: register file on Avalon-MM, line and dot
// timing against video sync, character fetch and colour/blank output.
// Assumes sync pins asynchronous, a glyph table outside answering
// glyph_row_bits combinationally from the registered glyph address.
//
// Operation
// - Master enable writable at any time; write-only, one bit used.
// - Master enable 0 hides display and opens all registers and RAM.
// - Master enable 1 shows words per visible flag; other access blocked (status register still reads).
// - Outline bit 0 draws box background; 1 draws fringe.
// - First row starts at four lines times vertical origin; zero illegal.
// - Space-backdrop-off 1 hides background on spaces; else enables rule.
// - First character starts at (10 + horizontal origin) pixel ticks.
// - Full-screen blank holds blanking output always; else only drawing.
// - Gap flag inserts four lines times line-gap value after a row.
// - Size bits pick height 18/36/54/72 lines, width 6/12/18/24 ticks.
// - Space with gap flag adds (1 + word-gap value) ticks after it.
// - Extra word gap scales by 2, 3 or 4 with character size.
// - Each background colour comes from its own three RGB bits.
// - Selected background enable bit decides background on next word.
// - Bank bit picks glyph bank, 0 lower; change only while disabled.
// - Column 0 is a hidden header setting size, gap and first word.
// - Space sets colour, backdrop, visibility and gap flag of next word.
// - Character RAM holds 80 seven-bit entries, five lines of sixteen.
// - Low four address bits are column; upper bits select the line.
// - Non-space entry indexes one of 64 glyphs in the chosen bank.
// - Entry bit 6 is 0 for glyph index, 1 for space character.
// - Oscillator starts at next vertical sync; stops at once on disable.
// - Smallest size dot spans two video lines and one pixel tick.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module oto_overlay (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Avalon-MM register slave
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Video sync pins
	input wire logic hsync_pin,
	input wire logic vsync_pin,
	// Glyph table
	output logic glyph_bank_bit,
	output logic [5:0] glyph_index,
	output logic [3:0] glyph_row,
	input wire logic [5:0] glyph_row_bits,
	// Video outputs
	output logic red,
	output logic green,
	output logic blue,
	output logic blanking_output
);
	logic [6:0] vorg_reg;
	logic [6:0] horg_reg;
	logic [6:0] gapb_reg;
	logic [7:0] wgsz_reg;
	logic [7:0] bkd_reg;
	logic display_master_on;
	logic rd_done_reg;
	logic wr_ok;
	logic ram_hit;
	logic [9:0] ram_off;
	logic [6:0] bus_ram_data;
	logic [31:0] rd_mux;
	logic hs_rise;
	logic vs_rise;
	logic hs_d_reg;
	logic osc_on_reg;
	logic osc_run;
	logic [4:0] tick_cnt_reg;
	logic pixel_tick;
	oto_pkg::oto_vstate_t vstate;
	oto_pkg::oto_hstate_t hstate;
	logic [9:0] line_cnt_reg;
	logic [2:0] disp_line_reg;
	logic [3:0] sub_line_reg;
	logic [3:0] grow_reg;
	logic [7:0] vgap_reg;
	logic [6:0] hdr_data;
	logic [2:0] row_scale;
	logic last_disp_line;
	logic [3:0] col_reg;
	logic [9:0] cnt_reg;
	logic [2:0] dsub_reg;
	logic [2:0] dcol_reg;
	logic [2:0] line_scale_reg;
	logic [2:0] word_rgb_reg;
	logic word_bgs_reg;
	logic word_we_reg;
	logic [6:0] entry;
	logic is_space;
	logic [6:0] lead_last;
	logic [9:0] gap_ticks;
	logic s_in_char;
	logic s_in_gap;
	logic s_is_space;
	logic [2:0] s_dcol;
	logic [2:0] s_rgb;
	logic s_bgs;
	logic s_we;
	logic [2:0] bitpos;
	logic fg;
	logic fringe_hit;
	logic bg_on;
	logic [2:0] bg_rgb;
	logic bg_draw;
	logic visible;

	////////////////////////////////////////////////////////////////////////
	// Bus decode. Reads take one wait state; writes complete at once.
	assign ram_off = avs_address - oto_pkg::RAM_BASE;
	assign ram_hit = (avs_address >= oto_pkg::RAM_BASE) && !ram_off[9]
		&& (ram_off[8:2] < oto_pkg::RAM_ENTRIES);
	assign wr_ok = avs_write && ((avs_address == oto_pkg::MEN_OFS)
		|| !display_master_on);
	assign avs_waitrequest = avs_read && !rd_done_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			display_master_on <= 1'b0;
		end else if (wr_ok && avs_address == oto_pkg::MEN_OFS) begin
			display_master_on <= avs_writedata[0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vorg_reg <= oto_pkg::VORG_RST;
			horg_reg <= oto_pkg::HORG_RST;
			gapb_reg <= oto_pkg::GAPB_RST;
			wgsz_reg <= oto_pkg::WGSZ_RST;
			bkd_reg <= oto_pkg::BKD_RST;
		end else if (wr_ok && !display_master_on) begin
			if (avs_address == oto_pkg::VORG_OFS) begin
				vorg_reg <= avs_writedata[6:0];
			end else if (avs_address == oto_pkg::HORG_OFS) begin
				horg_reg <= avs_writedata[6:0];
			end else if (avs_address == oto_pkg::GAPB_OFS) begin
				gapb_reg <= avs_writedata[6:0];
			end else if (avs_address == oto_pkg::WGSZ_OFS) begin
				wgsz_reg <= avs_writedata[7:0];
			end else if (avs_address == oto_pkg::BKD_OFS) begin
				bkd_reg <= avs_writedata[7:0];
			end
		end
	end

	// The bank has no guaranteed value for software; 0 after reset only
	// so that the glyph address is never undefined.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			glyph_bank_bit <= 1'b0;
		end else if (wr_ok && !display_master_on
			&& avs_address == oto_pkg::BANK_OFS) begin
			glyph_bank_bit <= avs_writedata[0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (avs_address == oto_pkg::STAT_OFS) begin
			rd_mux = {26'h0, disp_line_reg, vstate == oto_pkg::V_ROW,
				osc_run, display_master_on};
		end else if (display_master_on) begin
			rd_mux = 32'h0000_0000;
		end else if (avs_address == oto_pkg::VORG_OFS) begin
			rd_mux = {25'h0, vorg_reg};
		end else if (avs_address == oto_pkg::HORG_OFS) begin
			rd_mux = {25'h0, horg_reg};
		end else if (avs_address == oto_pkg::GAPB_OFS) begin
			rd_mux = {25'h0, gapb_reg};
		end else if (avs_address == oto_pkg::WGSZ_OFS) begin
			rd_mux = {24'h0, wgsz_reg};
		end else if (avs_address == oto_pkg::BKD_OFS) begin
			rd_mux = {24'h0, bkd_reg};
		end else if (avs_address == oto_pkg::BANK_OFS) begin
			rd_mux = {31'h0, glyph_bank_bit};
		end else if (ram_hit) begin
			rd_mux = {25'h0, bus_ram_data};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_done_reg <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			rd_done_reg <= avs_read && !rd_done_reg;
			if (avs_read && !rd_done_reg) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	oto_char_ram u_ram (
		.sys_clk(sys_clk),
		.wr_en(wr_ok && ram_hit && !display_master_on),
		.wr_idx(ram_off[8:2]),
		.wr_data(avs_writedata[6:0]),
		.bus_idx(ram_off[8:2]),
		.bus_data(bus_ram_data),
		.disp_idx({disp_line_reg, col_reg}),
		.disp_data(entry),
		.hdr_line(disp_line_reg),
		.hdr_data(hdr_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Sync inputs and the overlay oscillator.
	oto_sync u_hsync (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(hsync_pin),
		.rise_pulse(hs_rise)
	);

	oto_sync u_vsync (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(vsync_pin),
		.rise_pulse(vs_rise)
	);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			osc_on_reg <= 1'b0;
		end else if (!display_master_on) begin
			osc_on_reg <= 1'b0;
		end else if (vs_rise) begin
			osc_on_reg <= 1'b1;
		end
	end

	// Gating with the enable stops output in the very cycle it clears.
	assign osc_run = osc_on_reg && display_master_on;

	// The tick phase restarts on each line so dots line up vertically.
	always_ff @(posedge sys_clk) begin
		if (reset || hs_rise || !osc_run) begin
			tick_cnt_reg <= 5'h00;
		end else if (tick_cnt_reg == oto_pkg::TICK_LAST) begin
			tick_cnt_reg <= 5'h00;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 5'h01;
		end
	end

	assign pixel_tick = osc_run && (tick_cnt_reg == oto_pkg::TICK_LAST);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hs_d_reg <= 1'b0;
		end else begin
			hs_d_reg <= hs_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Vertical sequencing: one step per video line.
	assign row_scale = oto_pkg::size_scale(wgsz_reg[7:6],
		hdr_data[oto_pkg::HDR_S_BIT]);
	assign last_disp_line = disp_line_reg == oto_pkg::LAST_DISP_LINE;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vstate <= oto_pkg::V_DONE;
			line_cnt_reg <= 10'h000;
			disp_line_reg <= 3'h0;
			sub_line_reg <= 4'h0;
			grow_reg <= 4'h0;
			vgap_reg <= 8'h00;
		end else if (vs_rise) begin
			vstate <= oto_pkg::V_WAIT;
			line_cnt_reg <= 10'h000;
			disp_line_reg <= 3'h0;
			sub_line_reg <= 4'h0;
			grow_reg <= 4'h0;
		end else if (hs_rise) begin
			line_cnt_reg <= line_cnt_reg + 10'h001;
			case (vstate)
				oto_pkg::V_WAIT: begin
					if (line_cnt_reg + 10'h001
						== {2'b00, vorg_reg[5:0], 2'b00}) begin
						vstate <= oto_pkg::V_ROW;
					end
				end
				oto_pkg::V_ROW: begin
					if (sub_line_reg == {row_scale, 1'b0} - 4'h1) begin
						sub_line_reg <= 4'h0;
						if (grow_reg == oto_pkg::GLYPH_LAST_ROW) begin
							grow_reg <= 4'h0;
							if (hdr_data[oto_pkg::GAPF_BIT]) begin
								vstate <= oto_pkg::V_GAP;
								vgap_reg <= {gapb_reg[5:0], 2'b00} - 8'h01;
							end else if (last_disp_line) begin
								vstate <= oto_pkg::V_DONE;
							end else begin
								disp_line_reg <= disp_line_reg + 3'h1;
							end
						end else begin
							grow_reg <= grow_reg + 4'h1;
						end
					end else begin
						sub_line_reg <= sub_line_reg + 4'h1;
					end
				end
				oto_pkg::V_GAP: begin
					if (vgap_reg == 8'h00) begin
						vstate <= last_disp_line ? oto_pkg::V_DONE
							: oto_pkg::V_ROW;
						if (!last_disp_line) begin
							disp_line_reg <= disp_line_reg + 3'h1;
						end
					end else begin
						vgap_reg <= vgap_reg - 8'h01;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Horizontal sequencing: one step per pixel tick.
	assign is_space = entry[oto_pkg::KIND_BIT];
	assign lead_last = oto_pkg::LEAD_BASE_TICKS - 7'h01
		+ {1'b0, horg_reg[5:0]};
	assign gap_ticks = 10'(({1'b0, wgsz_reg[5:0]} + 7'h01)
		* line_scale_reg);

	always_ff @(posedge sys_clk) begin
		if (reset || !osc_run) begin
			hstate <= oto_pkg::H_IDLE;
			col_reg <= 4'h0;
			cnt_reg <= 10'h000;
			dsub_reg <= 3'h0;
			dcol_reg <= 3'h0;
			line_scale_reg <= 3'h1;
			word_rgb_reg <= 3'h0;
			word_bgs_reg <= 1'b0;
			word_we_reg <= 1'b0;
		end else if (hs_d_reg) begin
			col_reg <= 4'h0;
			cnt_reg <= 10'h000;
			line_scale_reg <= row_scale;
			word_rgb_reg <= hdr_data[oto_pkg::RGB_LSB +: 3];
			word_bgs_reg <= hdr_data[oto_pkg::BGS_BIT];
			word_we_reg <= hdr_data[oto_pkg::WE_BIT];
			hstate <= (vstate == oto_pkg::V_ROW) ? oto_pkg::H_LEAD
				: oto_pkg::H_IDLE;
		end else if (pixel_tick) begin
			case (hstate)
				oto_pkg::H_LEAD: begin
					if (cnt_reg[6:0] == lead_last) begin
						hstate <= oto_pkg::H_CHAR;
						col_reg <= 4'h1;
						dsub_reg <= 3'h0;
						dcol_reg <= 3'h0;
					end else begin
						cnt_reg <= cnt_reg + 10'h001;
					end
				end
				oto_pkg::H_CHAR: begin
					if (dsub_reg == line_scale_reg - 3'h1) begin
						dsub_reg <= 3'h0;
						if (dcol_reg == oto_pkg::GLYPH_LAST_COL) begin
							dcol_reg <= 3'h0;
							if (is_space) begin
								word_rgb_reg <= entry[oto_pkg::RGB_LSB +: 3];
								word_bgs_reg <= entry[oto_pkg::BGS_BIT];
								word_we_reg <= entry[oto_pkg::WE_BIT];
							end
							if (is_space && entry[oto_pkg::GAPF_BIT]) begin
								hstate <= oto_pkg::H_GAP;
								cnt_reg <= gap_ticks - 10'h001;
							end else if (col_reg == oto_pkg::LAST_COL) begin
								hstate <= oto_pkg::H_IDLE;
							end else begin
								col_reg <= col_reg + 4'h1;
							end
						end else begin
							dcol_reg <= dcol_reg + 3'h1;
						end
					end else begin
						dsub_reg <= dsub_reg + 3'h1;
					end
				end
				oto_pkg::H_GAP: begin
					if (cnt_reg != 10'h000) begin
						cnt_reg <= cnt_reg - 10'h001;
					end else if (col_reg == oto_pkg::LAST_COL) begin
						hstate <= oto_pkg::H_IDLE;
					end else begin
						hstate <= oto_pkg::H_CHAR;
						col_reg <= col_reg + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Glyph fetch stage: the table answers for the registered address, so
	// the drawing state is delayed by the same cycle.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			glyph_index <= 6'h00;
			glyph_row <= 4'h0;
			s_in_char <= 1'b0;
			s_in_gap <= 1'b0;
			s_is_space <= 1'b0;
			s_dcol <= 3'h0;
			s_rgb <= 3'h0;
			s_bgs <= 1'b0;
			s_we <= 1'b0;
		end else begin
			glyph_index <= entry[5:0];
			glyph_row <= grow_reg;
			s_in_char <= hstate == oto_pkg::H_CHAR;
			s_in_gap <= hstate == oto_pkg::H_GAP;
			s_is_space <= is_space;
			s_dcol <= dcol_reg;
			s_rgb <= word_rgb_reg;
			s_bgs <= word_bgs_reg;
			s_we <= word_we_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pixel composition. Fringe marks dots beside a lit dot in the row.
	assign bitpos = oto_pkg::GLYPH_LAST_COL - s_dcol;
	assign fg = s_in_char && !s_is_space && glyph_row_bits[bitpos];
	assign fringe_hit = s_in_char && !s_is_space
		&& ((s_dcol != 3'h0) && glyph_row_bits[3'(bitpos + 3'h1)]
		|| (s_dcol != oto_pkg::GLYPH_LAST_COL)
		&& glyph_row_bits[3'(bitpos - 3'h1)]);
	assign bg_on = s_bgs ? bkd_reg[oto_pkg::BK_ON1_BIT]
		: bkd_reg[oto_pkg::BK_ON0_BIT];
	assign bg_rgb = s_bgs ? bkd_reg[oto_pkg::BK_C1_LSB +: 3]
		: bkd_reg[oto_pkg::BK_C0_LSB +: 3];
	assign bg_draw = bg_on && !fg
		&& !(((s_in_char && s_is_space) || s_in_gap)
		&& horg_reg[oto_pkg::FLAG_BIT])
		&& (vorg_reg[oto_pkg::FLAG_BIT] ? fringe_hit
		: (s_in_char || s_in_gap));
	assign visible = s_we && osc_run;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			{red, green, blue} <= 3'h0;
			blanking_output <= 1'b0;
		end else begin
			if (visible && fg) begin
				{red, green, blue} <= s_rgb;
			end else if (visible && bg_draw) begin
				{red, green, blue} <= bg_rgb;
			end else begin
				{red, green, blue} <= 3'h0;
			end
			blanking_output <= gapb_reg[oto_pkg::FLAG_BIT]
				|| (visible && (fg || bg_draw));
		end
	end
endmodule // oto_overlay

/* File: oto_overlay_checker.sv */
// Checker for the overlay: bus handshake, access gating and output rules.
// Assumes it is bound to oto_overlay and sees only that module's ports.
`timescale 1ns/1ps
module oto_overlay_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register bus
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Outputs
	input wire logic glyph_bank_bit,
	input wire logic red,
	input wire logic green,
	input wire logic blue,
	input wire logic blanking_output
);
	logic men_reg;
	logic scb_reg;
	logic lit;
	logic bank_wr;
	assign lit = red | green | blue;
	assign bank_wr = avs_write && avs_address == oto_pkg::BANK_OFS && !men_reg;
	always_ff @(posedge sys_clk) begin
		if (reset)
			men_reg <= 1'b0;
		else if (avs_write && avs_address == oto_pkg::MEN_OFS)
			men_reg <= avs_writedata[0];
	end
	// Blank bit is only writable while the display is off.
	always_ff @(posedge sys_clk) begin
		if (reset)
			scb_reg <= 1'b0;
		else if (avs_write && avs_address == oto_pkg::GAPB_OFS && !men_reg)
			scb_reg <= avs_writedata[6];
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_wr_nowait;
		avs_write |-> !avs_waitrequest;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_rd_wait;
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_blocked_rd;
		men_reg && avs_read && !avs_waitrequest &&
			avs_address != oto_pkg::STAT_OFS |-> avs_readdata == 32'h0;
	endproperty
	a_blocked_rd: assert property (p_blocked_rd) else $error("read not blocked");
	property p_lit_blank;
		lit |-> blanking_output;
	endproperty
	a_lit_blank: assert property (p_lit_blank) else $error("colour unblanked");
	property p_off_dark;
		avs_write && avs_address == oto_pkg::MEN_OFS && !avs_writedata[0]
			|-> ##3 !lit;
	endproperty
	a_off_dark: assert property (p_off_dark) else $error("lit after off");
	property p_dark_off;
		!men_reg && !$past(men_reg) && !$past(men_reg, 2) && !$past(men_reg, 3)
			|-> !lit;
	endproperty
	a_dark_off: assert property (p_dark_off) else $error("lit while off");
	property p_bank_hold;
		$changed(glyph_bank_bit) |-> $past(bank_wr);
	endproperty
	a_bank_hold: assert property (p_bank_hold) else $error("bank moved");
	property p_scb;
		scb_reg && $past(scb_reg) && $past(scb_reg, 2) && $past(scb_reg, 3)
			|-> blanking_output;
	endproperty
	a_scb: assert property (p_scb) else $error("screen not blanked");
	c_draw: cover property (lit && blanking_output);
	c_blocked: cover property (men_reg && avs_read && !avs_waitrequest);
	c_bank: cover property ($changed(glyph_bank_bit));
endmodule // oto_overlay_checker

bind oto_overlay oto_overlay_checker u_chk (.sys_clk, .reset, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.glyph_bank_bit, .red, .green, .blue, .blanking_output);

/* File: oto_tv_model.sv */
// Far side model: free-running video sync source and glyph table.
// Assumes one sys_clk; the line is short to keep frames quick.
`timescale 1ns/1ps
module oto_tv_model #(
	parameter int LINE_CYC = 1800,
	parameter int FRAME_LINES = 24
) (
	// Clock
	input wire logic sys_clk,
	// Sync pins
	output logic hsync_pin,
	output logic vsync_pin,
	// Glyph table
	input wire logic glyph_bank_bit,
	input wire logic [5:0] glyph_index,
	input wire logic [3:0] glyph_row,
	output logic [5:0] glyph_row_bits
);
	int pix = 0;
	int line = 0;
	always_ff @(posedge sys_clk) begin
		if (pix == LINE_CYC - 1) begin
			pix <= 0;
			line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
		end else
			pix <= pix + 1;
	end
	assign hsync_pin = pix < 40;
	assign vsync_pin = line == 0 && pix < 400;
	// Pattern depends on bank so a wrong bank shows in the dots.
	assign glyph_row_bits = (glyph_index ^ {2'b0, glyph_row} ^
		{6{glyph_bank_bit}}) | 6'h21;
endmodule // oto_tv_model

/* File: oto_overlay_bench.sv */
// Self-checking bench: register model compared at every rd read; the status read checks only the enable bit.
// Assumes the checker is bound and the TV model drives sync.
`timescale 1ns/1ps
module oto_overlay_bench;
	logic sys_clk;
	logic reset;
	logic [9:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic hsync_pin, vsync_pin, glyph_bank_bit;
	logic [5:0] glyph_index, glyph_row_bits;
	logic [3:0] glyph_row;
	logic red, green, blue, blanking_output;
	int err_total;
	int num_checks;
	logic [31:0] rm [int];
	bit men;
	bit [31:0] seed = 82370;
	logic [9:0] regs [9] = '{oto_pkg::VORG_OFS, oto_pkg::HORG_OFS,
		oto_pkg::GAPB_OFS, oto_pkg::WGSZ_OFS, oto_pkg::BKD_OFS,
		oto_pkg::BANK_OFS, oto_pkg::MEN_OFS, 10'h020, 10'h240};
	oto_overlay u_dut (.sys_clk, .reset, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.hsync_pin, .vsync_pin, .glyph_bank_bit, .glyph_index, .glyph_row,
		.glyph_row_bits, .red, .green, .blue, .blanking_output);
	oto_tv_model u_tv (.sys_clk, .hsync_pin, .vsync_pin, .glyph_bank_bit,
		.glyph_index, .glyph_row, .glyph_row_bits);
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// RAM words end at 0x240, four bytes per entry.
	function automatic logic [31:0] mask(input logic [9:0] a);
		if (a >= oto_pkg::RAM_BASE && a < 10'h240 && a[1:0] == 2'b0)
			return 32'h7f;
		case (a)
			oto_pkg::VORG_OFS, oto_pkg::HORG_OFS, oto_pkg::GAPB_OFS: return 32'h7f;
			oto_pkg::WGSZ_OFS, oto_pkg::BKD_OFS: return 32'hff;
			oto_pkg::BANK_OFS: return 32'h1;
			default: return 32'h0;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic xfer(input bit wr, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		if (n >= 64) begin
			err_total++;
			conclude();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (wr && a == oto_pkg::MEN_OFS)
			men = d[0];
		else if (wr && !men)
			rm[a] = d & mask(a);
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [9:0] a);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk($sformatf("word %h", a), q, (men || !rm.exists(a)) ? 0 : rm[a]);
	endtask
	task automatic wait_blank(input int lim, input string nm);
		int n;
		for (n = 0; n < lim && blanking_output !== 1'b1; n++)
			@(posedge sys_clk);
		chk(nm, {31'h0, blanking_output}, 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		logic [31:0] d;
		reset = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		rm[oto_pkg::VORG_OFS] = 32'(oto_pkg::VORG_RST);
		rm[oto_pkg::HORG_OFS] = 32'(oto_pkg::HORG_RST);
		rm[oto_pkg::GAPB_OFS] = 32'(oto_pkg::GAPB_RST);
		rm[oto_pkg::WGSZ_OFS] = 32'(oto_pkg::WGSZ_RST);
		rm[oto_pkg::BKD_OFS] = 32'(oto_pkg::BKD_RST);
		rm[oto_pkg::BANK_OFS] = 32'h0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (regs[i]) rd(regs[i]);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			foreach (regs[j]) begin
				d = rnd();
				d[0] = 1'b1;
				if (j != 6) wr(regs[j], d);
				rd(regs[j]);
			end
		end
		for (int i = 0; i < 80; i++) wr(oto_pkg::RAM_BASE + 10'(4 * i), rnd());
		for (int i = 0; i < 80; i++) rd(oto_pkg::RAM_BASE + 10'(4 * i));
		$display("test register and memory traffic done");
		wr(oto_pkg::RAM_BASE, 32'h3a);
		for (int c = 1; c < 16; c++) wr(oto_pkg::RAM_BASE + 10'(4 * c), c);
		wr(oto_pkg::VORG_OFS, 32'h1);
		wr(oto_pkg::HORG_OFS, 32'h0);
		wr(oto_pkg::GAPB_OFS, 32'h1);
		wr(oto_pkg::WGSZ_OFS, 32'h0);
		wr(oto_pkg::BKD_OFS, 32'h47);
		wr(oto_pkg::BANK_OFS, 32'h0);
		@(posedge sys_clk);
		chk("bank pin", {31'h0, glyph_bank_bit}, 32'h0);
		wr(oto_pkg::MEN_OFS, 32'h1);
		wr(oto_pkg::VORG_OFS, 32'h5);
		wr(oto_pkg::BANK_OFS, 32'h1);
		rd(oto_pkg::VORG_OFS);
		xfer(1'b0, oto_pkg::STAT_OFS, 32'h0, q);
		chk("status on", {31'h0, q[0]}, 32'h1);
		wait_blank(90000, "blank while drawing");
		chk("colour", {29'h0, red, green, blue}, 32'h7);
		wr(oto_pkg::MEN_OFS, 32'h0);
		rd(oto_pkg::VORG_OFS);
		rd(oto_pkg::BANK_OFS);
		$display("test display enable done");
		wr(oto_pkg::GAPB_OFS, 32'h41);
		wait_blank(16, "screen blank");
		$display("test screen blank done");
		conclude();
	end
endmodule // oto_overlay_bench
